/* File: dsc_sync_ctrl.sv */
// sync distribution and downconverter control registers
`timescale 1ns/1ps
module dsc_sync_ctrl (
  input  wire logic          i_clk,
  input  wire logic          i_reset_n,
  input  wire logic          i_sync,
  input  wire logic          i_sclk,
  input  wire logic          i_csn,
  input  wire logic          i_sdio,
  input  wire logic [19:0]   i_mon_result_a,
  input  wire logic [19:0]   i_mon_result_b,
  output logic               o_sdio,
  output logic               o_sdio_oe,
  output dsc_pkg::dsc_sync_t o_sync,
  output logic [31:0]        o_osc_phase,
  output logic [31:0]        o_osc_tuning_word,
  output logic               o_osc_enable,
  output logic               o_osc_amp_dither,
  output logic               o_osc_phase_dither,
  output logic               o_hb_phase,
  output logic               o_hb_high_pass,
  output logic               o_hb_spectral_rev,
  output logic [1:0]         o_mix_phase,
  output logic               o_mix_disable,
  output logic               o_complex_mode,
  output logic               o_fir_enable,
  output logic [1:0]         o_fir_gain,
  output logic [23:0]        o_mon_period
);
  dsc_pkg::dsc_st_t   st_r;
  dsc_pkg::dsc_st_t   st_nxt;
  dsc_pkg::dsc_bus_t  bus;
  dsc_pkg::dsc_sync_t hit;
  logic               sync_edge;
  logic               fire;
  logic [7:0]         sync_wr;
  logic               wr_sync;
  logic               wr_mix;

  dsc_spi_port u_spi (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_sclk    (i_sclk),
    .i_csn     (i_csn),
    .i_sdio    (i_sdio),
    .i_rdata   (st_r.rdata),
    .o_sdio    (o_sdio),
    .o_sdio_oe (o_sdio_oe),
    .o_bus     (bus)
  );

  // edge taken from second and third stage only
  assign sync_edge = st_r.sync_s & ~st_r.sync_d;
  assign fire      = sync_edge & st_r.sync_ctl[dsc_pkg::SY_MASTER];
  // one driver for the whole struct, fields named for clarity
  assign hit = '{
    clkdiv: fire & st_r.sync_ctl[dsc_pkg::SY_DIV_EN],
    osc:    fire & st_r.sync_ctl[dsc_pkg::SY_OSC_EN],
    hb:     fire & st_r.sync_ctl[dsc_pkg::SY_HB_EN],
    mix:    fire & st_r.mix_ctl[dsc_pkg::MX_EN],
    mon:    fire & st_r.sync_ctl[dsc_pkg::SY_MON_EN]
  };
  assign wr_sync   = bus.wr && bus.addr == dsc_pkg::ADDR_SYNC_CTL;
  assign wr_mix    = bus.wr && bus.addr == dsc_pkg::ADDR_MIX_CTL;

  always_comb begin
    sync_wr = st_r.sync_ctl;
    // first-pulse-only: drop the gate after its one sync
    if (hit.hb && st_r.sync_ctl[dsc_pkg::SY_HB_ONCE]) begin
      sync_wr[dsc_pkg::SY_HB_EN] = 1'b0;
    end
    if (hit.osc && st_r.sync_ctl[dsc_pkg::SY_OSC_ONCE]) begin
      sync_wr[dsc_pkg::SY_OSC_EN] = 1'b0;
    end
    if (hit.clkdiv && st_r.sync_ctl[dsc_pkg::SY_DIV_ONCE]) begin
      sync_wr[dsc_pkg::SY_DIV_EN] = 1'b0;
    end
    // kept as the map reads: the master bit is what drops
    if (hit.mix && st_r.mix_ctl[dsc_pkg::MX_ONCE]) begin
      sync_wr[dsc_pkg::SY_MASTER] = 1'b0;
    end
  end

  always_comb begin
    st_nxt          = st_r;
    st_nxt.sync_m   = i_sync;
    st_nxt.sync_s   = st_r.sync_m;
    st_nxt.sync_d   = st_r.sync_s;
    st_nxt.pulse    = hit;
    // gates without first-pulse-only keep their value
    st_nxt.sync_ctl = sync_wr;
    // half-band decimation phase toggles per sample
    st_nxt.hb_phase = ~st_r.hb_phase;
    if (hit.hb) begin
      st_nxt.hb_phase = st_r.hb_ctl[dsc_pkg::HB_ALTPHASE];
    end
    st_nxt.mix_phase = st_r.mix_phase + 2'h1;
    if (hit.mix) begin
      st_nxt.mix_phase = st_r.mix_ctl[dsc_pkg::MX_START_LO +: 2];
    end
    if (st_r.osc_ctl[0]) begin
      st_nxt.osc_acc = st_r.osc_acc + st_r.ftw;
    end
    if (hit.osc) begin
      st_nxt.osc_acc = {st_r.phase, 16'h0000};
    end
    // a software write in the same cycle overrides a hardware clear
    if (bus.wr) begin
      case (bus.addr)
        dsc_pkg::ADDR_SYNC_CTL: begin
          st_nxt.sync_ctl = bus.wdata;
        end
        dsc_pkg::ADDR_MIX_CTL: begin
          st_nxt.mix_ctl = bus.wdata & dsc_pkg::MASK_MIX;
        end
        dsc_pkg::ADDR_FIR_CTL: begin
          st_nxt.fir_ctl = bus.wdata & dsc_pkg::MASK_FIR;
        end
        dsc_pkg::ADDR_HB_CTL: begin
          st_nxt.hb_ctl = bus.wdata & dsc_pkg::MASK_HB;
        end
        dsc_pkg::ADDR_PERIOD0: begin
          st_nxt.mon_period[7:0] = bus.wdata;
        end
        dsc_pkg::ADDR_PERIOD1: begin
          st_nxt.mon_period[15:8] = bus.wdata;
        end
        dsc_pkg::ADDR_PERIOD2: begin
          st_nxt.mon_period[23:16] = bus.wdata;
        end
        dsc_pkg::ADDR_OSC_CTL: begin
          st_nxt.osc_ctl = bus.wdata & dsc_pkg::MASK_OSC;
        end
        dsc_pkg::ADDR_FTW0: begin
          st_nxt.ftw[7:0] = bus.wdata;
        end
        dsc_pkg::ADDR_FTW1: begin
          st_nxt.ftw[15:8] = bus.wdata;
        end
        dsc_pkg::ADDR_FTW2: begin
          st_nxt.ftw[23:16] = bus.wdata;
        end
        dsc_pkg::ADDR_FTW3: begin
          st_nxt.ftw[31:24] = bus.wdata;
        end
        dsc_pkg::ADDR_PHASE0: begin
          st_nxt.phase[7:0] = bus.wdata;
        end
        dsc_pkg::ADDR_PHASE1: begin
          st_nxt.phase[15:8] = bus.wdata;
        end
        default: begin
          st_nxt.rdata = st_r.rdata;
        end
      endcase
    end
    // short periods run at the floor, register keeps what was written
    if (st_r.mon_period < dsc_pkg::PERIOD_MIN) begin
      st_nxt.mon_eff = dsc_pkg::PERIOD_MIN;
    end else begin
      st_nxt.mon_eff = st_r.mon_period;
    end
    if (st_r.fir_ctl[dsc_pkg::FR_GAIN]) begin
      st_nxt.fir_gain = dsc_pkg::GAIN_ONE;
    end else begin
      st_nxt.fir_gain = dsc_pkg::GAIN_TWO;
    end
    // read data follows the held address every cycle, no side effects
    case (bus.addr)
      dsc_pkg::ADDR_SYNC_CTL: begin
        st_nxt.rdata = st_r.sync_ctl;
      end
      dsc_pkg::ADDR_MIX_CTL: begin
        st_nxt.rdata = st_r.mix_ctl;
      end
      dsc_pkg::ADDR_FIR_CTL: begin
        st_nxt.rdata = st_r.fir_ctl;
      end
      dsc_pkg::ADDR_HB_CTL: begin
        st_nxt.rdata = st_r.hb_ctl | (8'h01 << dsc_pkg::HB_FIXED1);
      end
      dsc_pkg::ADDR_PERIOD0: begin
        st_nxt.rdata = st_r.mon_period[7:0];
      end
      dsc_pkg::ADDR_PERIOD1: begin
        st_nxt.rdata = st_r.mon_period[15:8];
      end
      dsc_pkg::ADDR_PERIOD2: begin
        st_nxt.rdata = st_r.mon_period[23:16];
      end
      dsc_pkg::ADDR_RES_A0: begin
        st_nxt.rdata = i_mon_result_a[7:0];
      end
      dsc_pkg::ADDR_RES_A1: begin
        st_nxt.rdata = i_mon_result_a[15:8];
      end
      dsc_pkg::ADDR_RES_A2: begin
        st_nxt.rdata = {4'h0, i_mon_result_a[19:16]};
      end
      dsc_pkg::ADDR_RES_B0: begin
        st_nxt.rdata = i_mon_result_b[7:0];
      end
      dsc_pkg::ADDR_RES_B1: begin
        st_nxt.rdata = i_mon_result_b[15:8];
      end
      dsc_pkg::ADDR_RES_B2: begin
        st_nxt.rdata = {4'h0, i_mon_result_b[19:16]};
      end
      dsc_pkg::ADDR_OSC_CTL: begin
        st_nxt.rdata = st_r.osc_ctl;
      end
      dsc_pkg::ADDR_FTW0: begin
        st_nxt.rdata = st_r.ftw[7:0];
      end
      dsc_pkg::ADDR_FTW1: begin
        st_nxt.rdata = st_r.ftw[15:8];
      end
      dsc_pkg::ADDR_FTW2: begin
        st_nxt.rdata = st_r.ftw[23:16];
      end
      dsc_pkg::ADDR_FTW3: begin
        st_nxt.rdata = st_r.ftw[31:24];
      end
      dsc_pkg::ADDR_PHASE0: begin
        st_nxt.rdata = st_r.phase[7:0];
      end
      dsc_pkg::ADDR_PHASE1: begin
        st_nxt.rdata = st_r.phase[15:8];
      end
      default: begin
        st_nxt.rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st_r            <= '0;
      st_r.sync_ctl   <= dsc_pkg::RST_SYNC;
      st_r.mix_ctl    <= dsc_pkg::RST_MIX;
      st_r.fir_ctl    <= dsc_pkg::RST_FIR;
      st_r.hb_ctl     <= dsc_pkg::RST_HB;
      st_r.osc_ctl    <= dsc_pkg::RST_OSC;
      st_r.mon_period <= dsc_pkg::RST_PERIOD;
      st_r.mon_eff    <= dsc_pkg::RST_PERIOD;
      st_r.ftw        <= dsc_pkg::RST_FTW;
      st_r.phase      <= dsc_pkg::RST_PHASE;
      st_r.fir_gain   <= dsc_pkg::GAIN_TWO;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_sync             = st_r.pulse;
  assign o_osc_phase        = st_r.osc_acc;
  assign o_osc_tuning_word  = st_r.ftw;
  assign o_osc_enable       = st_r.osc_ctl[0];
  assign o_osc_amp_dither   = st_r.osc_ctl[1];
  assign o_osc_phase_dither = st_r.osc_ctl[2];
  assign o_hb_phase         = st_r.hb_phase;
  assign o_hb_high_pass     = st_r.hb_ctl[dsc_pkg::HB_HIGHPASS];
  assign o_hb_spectral_rev  = st_r.hb_ctl[dsc_pkg::HB_SPECREV];
  assign o_mix_phase        = st_r.mix_phase;
  assign o_mix_disable      = st_r.fir_ctl[dsc_pkg::FR_MIX_DIS];
  assign o_complex_mode     = st_r.fir_ctl[dsc_pkg::FR_COMPLEX];
  assign o_fir_enable       = st_r.fir_ctl[dsc_pkg::FR_ENABLE];
  assign o_fir_gain         = st_r.fir_gain;
  assign o_mon_period       = st_r.mon_eff;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  a_master_gate: assert property (
    !st_r.sync_ctl[dsc_pkg::SY_MASTER] |=> st_r.pulse == '0)
    else $error("sync forwarded without master enable");

  a_mon_forward: assert property (
    sync_edge && st_r.sync_ctl[dsc_pkg::SY_MASTER] && st_r.sync_ctl[dsc_pkg::SY_MON_EN]
    |=> st_r.pulse.mon)
    else $error("monitor sync not forwarded");

  a_hb_restart: assert property (
    hit.hb |=> st_r.hb_phase == $past(st_r.hb_ctl[dsc_pkg::HB_ALTPHASE]) ##1
    st_r.hb_phase != $past(st_r.hb_phase))
    else $error("half-band phase not restarted");

  a_hb_once: assert property (
    hit.hb && st_r.sync_ctl[dsc_pkg::SY_HB_ONCE] && !wr_sync
    |=> !st_r.sync_ctl[dsc_pkg::SY_HB_EN])
    else $error("half-band gate not cleared");

  a_osc_load: assert property (
    hit.osc |=> st_r.osc_acc == {$past(st_r.phase), 16'h0000})
    else $error("oscillator not loaded with phase offset");

  a_osc_once: assert property (
    hit.osc && st_r.sync_ctl[dsc_pkg::SY_OSC_ONCE] && !wr_sync
    |=> !st_r.sync_ctl[dsc_pkg::SY_OSC_EN])
    else $error("oscillator gate not cleared");

  a_div_forward: assert property (
    st_r.pulse.clkdiv |-> $past(fire) && $past(st_r.sync_ctl[dsc_pkg::SY_DIV_EN]))
    else $error("divider sync without its gate");

  a_div_once: assert property (
    hit.clkdiv && st_r.sync_ctl[dsc_pkg::SY_DIV_ONCE] && !wr_sync
    |=> !st_r.sync_ctl[dsc_pkg::SY_DIV_EN])
    else $error("divider gate not cleared");

  a_mix_once: assert property (
    hit.mix && st_r.mix_ctl[dsc_pkg::MX_ONCE] && !wr_sync
    |=> !st_r.sync_ctl[dsc_pkg::SY_MASTER] ##1 st_r.pulse == '0)
    else $error("master not cleared after mixer sync");

  a_mix_start: assert property (
    hit.mix |=> st_r.mix_phase == $past(st_r.mix_ctl[5:4]))
    else $error("mixer not started at start state");

  a_fir_gain: assert property (
    st_r.fir_ctl[dsc_pkg::FR_GAIN] && !bus.wr |=> o_fir_gain == dsc_pkg::GAIN_ONE)
    else $error("filter gain wrong");

  a_period_floor: assert property (
    ##1 o_mon_period >= dsc_pkg::PERIOD_MIN)
    else $error("monitor period below floor");

  a_gate_held: assert property (
    hit.hb && !st_r.sync_ctl[dsc_pkg::SY_HB_ONCE] && !wr_sync
    |=> st_r.sync_ctl[dsc_pkg::SY_HB_EN])
    else $error("continuous gate dropped");
endmodule

/* File: dsc_pkg.sv */
// constants and types for the sync distribution control block
// Contract
// - no sync passes without master enable
// - monitor gets every sync when enabled
// - half-band restarts at selected decimation phase
// - half-band first-pulse-only clears its gate
// - oscillator accumulator restarts at phase offset
// - oscillator first-pulse-only clears its gate
// - clock divider gets sync when enabled
// - divider first-pulse-only clears its gate
// - mixer sync gated by own enable
// - mixer first-pulse-only clears master enable
// - start state sets mixer starting phase
// - monitor period 24 bits, default 0x80
// - channel A result read-only, three bytes
// - channel B result laid out likewise
// - phase offset 16 bits, low byte first
// - alternate-phase bit selects half-band phase
// - results 20 bits, top nibble in third
package dsc_pkg;
  localparam logic [12:0] ADDR_SYNC_CTL = 13'h0100;
  localparam logic [12:0] ADDR_MIX_CTL  = 13'h0101;
  localparam logic [12:0] ADDR_FIR_CTL  = 13'h0102;
  localparam logic [12:0] ADDR_HB_CTL   = 13'h0103;
  localparam logic [12:0] ADDR_PERIOD0  = 13'h0113;
  localparam logic [12:0] ADDR_PERIOD1  = 13'h0114;
  localparam logic [12:0] ADDR_PERIOD2  = 13'h0115;
  localparam logic [12:0] ADDR_RES_A0   = 13'h0116;
  localparam logic [12:0] ADDR_RES_A1   = 13'h0117;
  localparam logic [12:0] ADDR_RES_A2   = 13'h0118;
  localparam logic [12:0] ADDR_RES_B0   = 13'h0119;
  localparam logic [12:0] ADDR_RES_B1   = 13'h011A;
  localparam logic [12:0] ADDR_RES_B2   = 13'h011B;
  localparam logic [12:0] ADDR_OSC_CTL  = 13'h011D;
  localparam logic [12:0] ADDR_FTW0     = 13'h011E;
  localparam logic [12:0] ADDR_FTW1     = 13'h011F;
  localparam logic [12:0] ADDR_FTW2     = 13'h0120;
  localparam logic [12:0] ADDR_FTW3     = 13'h0121;
  localparam logic [12:0] ADDR_PHASE0   = 13'h0122;
  localparam logic [12:0] ADDR_PHASE1   = 13'h0123;
  // sync, mixer, filter and half-band control bit positions
  localparam int unsigned SY_MASTER   = 0;
  localparam int unsigned SY_DIV_EN   = 1;
  localparam int unsigned SY_DIV_ONCE = 2;
  localparam int unsigned SY_OSC_EN   = 3;
  localparam int unsigned SY_OSC_ONCE = 4;
  localparam int unsigned SY_HB_EN    = 5;
  localparam int unsigned SY_HB_ONCE  = 6;
  localparam int unsigned SY_MON_EN   = 7;
  localparam int unsigned MX_EN       = 0;
  localparam int unsigned MX_ONCE     = 1;
  localparam int unsigned MX_START_LO = 4;
  localparam int unsigned FR_ENABLE   = 0;
  localparam int unsigned FR_COMPLEX  = 1;
  localparam int unsigned FR_MIX_DIS  = 2;
  localparam int unsigned FR_GAIN     = 3;
  localparam int unsigned HB_FIXED1   = 0;
  localparam int unsigned HB_HIGHPASS = 1;
  localparam int unsigned HB_SPECREV  = 2;
  localparam int unsigned HB_ALTPHASE = 3;
  // writable bits; the rest read zero, except half-band bit 0, which reads one
  localparam logic [7:0]  MASK_MIX    = 8'h33;
  localparam logic [7:0]  MASK_FIR    = 8'h0F;
  localparam logic [7:0]  MASK_HB     = 8'h0E;
  localparam logic [7:0]  MASK_OSC    = 8'h07;
  localparam logic [7:0]  RST_SYNC    = 8'h00;
  localparam logic [7:0]  RST_MIX     = 8'h00;
  localparam logic [7:0]  RST_FIR     = 8'h00;
  localparam logic [7:0]  RST_HB      = 8'h00;
  localparam logic [7:0]  RST_OSC     = 8'h00;
  localparam logic [23:0] RST_PERIOD  = 24'h000080;
  localparam logic [23:0] PERIOD_MIN  = 24'h000080;
  localparam logic [31:0] RST_FTW     = 32'h00000000;
  localparam logic [15:0] RST_PHASE   = 16'h0000;
  localparam logic [1:0]  GAIN_ONE    = 2'h1;
  localparam logic [1:0]  GAIN_TWO    = 2'h2;
  localparam logic [4:0]  SPI_INSTR_LAST = 5'h0F;
  localparam logic [4:0]  SPI_DATA_FIRST = 5'h10;
  localparam logic [4:0]  SPI_DATA_LAST  = 5'h17;
  localparam logic [4:0]  SPI_DONE       = 5'h18;

  typedef struct packed {
    logic        wr;
    logic [12:0] addr;
    logic [7:0]  wdata;
  } dsc_bus_t;

  typedef struct packed {
    logic clkdiv;
    logic osc;
    logic hb;
    logic mix;
    logic mon;
  } dsc_sync_t;

  typedef struct packed {
    logic        sclk_m;
    logic        sclk_s;
    logic        sclk_d;
    logic        csn_m;
    logic        csn_s;
    logic        sdi_m;
    logic        sdi_s;
    logic [4:0]  cnt;
    logic [15:0] instr;
    logic [7:0]  wsh;
    logic [7:0]  rsh;
    logic        sdo;
    logic        oe;
    dsc_bus_t    bus;
  } dsc_spi_st_t;

  typedef struct packed {
    logic        sync_m;
    logic        sync_s;
    logic        sync_d;
    logic [7:0]  sync_ctl;
    logic [7:0]  mix_ctl;
    logic [7:0]  fir_ctl;
    logic [7:0]  hb_ctl;
    logic [23:0] mon_period;
    logic [23:0] mon_eff;
    logic [7:0]  osc_ctl;
    logic [31:0] ftw;
    logic [15:0] phase;
    logic [31:0] osc_acc;
    logic        hb_phase;
    logic [1:0]  mix_phase;
    logic [1:0]  fir_gain;
    dsc_sync_t   pulse;
    logic [7:0]  rdata;
  } dsc_st_t;
endpackage

/* File: dsc_spi_port.sv */
// serial register port slave, single byte per frame
`timescale 1ns/1ps
module dsc_spi_port (
  input  wire logic             i_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_sclk,
  input  wire logic             i_csn,
  input  wire logic             i_sdio,
  input  wire logic [7:0]       i_rdata,
  output logic                  o_sdio,
  output logic                  o_sdio_oe,
  output dsc_pkg::dsc_bus_t     o_bus
);
  dsc_pkg::dsc_spi_st_t st_r;
  dsc_pkg::dsc_spi_st_t st_nxt;
  logic                 rise;
  logic                 fall;
  logic                 rd_mode;

  // edges seen only after both synchroniser stages
  assign rise    = st_r.sclk_s & ~st_r.sclk_d;
  assign fall    = ~st_r.sclk_s & st_r.sclk_d;
  assign rd_mode = st_r.instr[15];

  always_comb begin
    st_nxt        = st_r;
    st_nxt.sclk_m = i_sclk;
    st_nxt.sclk_s = st_r.sclk_m;
    st_nxt.sclk_d = st_r.sclk_s;
    st_nxt.csn_m  = i_csn;
    st_nxt.csn_s  = st_r.csn_m;
    st_nxt.sdi_m  = i_sdio;
    st_nxt.sdi_s  = st_r.sdi_m;
    st_nxt.bus.wr = 1'b0;
    if (st_r.csn_s) begin
      st_nxt.cnt = 5'h00;
      st_nxt.oe  = 1'b0;
    end else if (rise) begin
      if (st_r.cnt <= dsc_pkg::SPI_INSTR_LAST) begin
        st_nxt.instr = {st_r.instr[14:0], st_r.sdi_s};
      end else if (!rd_mode) begin
        st_nxt.wsh = {st_r.wsh[6:0], st_r.sdi_s};
      end
      // address held for the read mux from here on
      if (st_r.cnt == dsc_pkg::SPI_INSTR_LAST) begin
        st_nxt.bus.addr = {st_r.instr[11:0], st_r.sdi_s};
      end
      if (st_r.cnt == dsc_pkg::SPI_DATA_LAST && !rd_mode) begin
        st_nxt.bus.wr    = 1'b1;
        st_nxt.bus.wdata = {st_r.wsh[6:0], st_r.sdi_s};
      end
      // further bits of a streamed frame are ignored
      if (st_r.cnt != dsc_pkg::SPI_DONE) begin
        st_nxt.cnt = st_r.cnt + 5'h01;
      end
    end else if (fall && rd_mode && st_r.cnt >= dsc_pkg::SPI_DATA_FIRST
                 && st_r.cnt <= dsc_pkg::SPI_DATA_LAST) begin
      st_nxt.oe = 1'b1;
      if (st_r.cnt == dsc_pkg::SPI_DATA_FIRST) begin
        st_nxt.sdo = i_rdata[7];
        st_nxt.rsh = {i_rdata[6:0], 1'b0};
      end else begin
        st_nxt.sdo = st_r.rsh[7];
        st_nxt.rsh = {st_r.rsh[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st_r       <= '0;
      st_r.csn_m <= 1'b1;
      st_r.csn_s <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_sdio    = st_r.sdo;
  assign o_sdio_oe = st_r.oe;
  assign o_bus     = st_r.bus;
endmodule

/* File: dsc_host.sv */
// serial register host and sync source model
`timescale 1ns/1ps
module dsc_host (
  input  wire logic i_clk,
  input  wire logic i_sdio,
  output logic      o_sclk,
  output logic      o_csn,
  output logic      o_sdio,
  output logic      o_sync
);
  initial begin
    o_sclk = 1'b0;
    o_csn  = 1'b1;
    o_sdio = 1'b0;
    o_sync = 1'b0;
  end

  // half periods of 5 clk keep clear of the 4 clk minimum
  task automatic xfer(input logic [15:0] ins, input logic [7:0] wd, output logic [7:0] rd);
    logic [23:0] sh;
    sh = {ins, wd};
    rd = 8'h00;
    @(negedge i_clk);
    o_csn = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      // released line toggles so a stale bit never reads back
      o_sdio = (i < 8 && ins[15]) ? ~o_sdio : sh[i];
      repeat (5) @(negedge i_clk);
      rd[i % 8] = i_sdio;
      o_sclk = 1'b1;
      repeat (5) @(negedge i_clk);
      o_sclk = 1'b0;
    end
    o_csn = 1'b1;
    repeat (6) @(negedge i_clk);
  endtask

  // pin high for 3 clk and low for 6 clk, above the 2 clk minimum
  task automatic pulse();
    @(negedge i_clk);
    o_sync = 1'b1;
    repeat (3) @(negedge i_clk);
    o_sync = 1'b0;
    repeat (6) @(negedge i_clk);
  endtask
endmodule

/* File: dsc_sync_ctrl_tb.sv */
// self-checking bench for the sync distribution control block
`timescale 1ns/1ps
module dsc_sync_ctrl_tb;
  logic               i_clk;
  logic               i_reset_n;
  logic               sclk;
  logic               csn;
  logic               h_sdio;
  logic               d_sdio;
  logic               d_oe;
  logic               sdio_w;
  logic               sync;
  logic [19:0]        res_a;
  logic [19:0]        res_b;
  dsc_pkg::dsc_sync_t pls;
  logic [31:0]        phs;
  logic [31:0]        ftw;
  logic               osc_en;
  logic               amp_d;
  logic               ph_d;
  logic               hb;
  logic [1:0]         mix;
  logic [1:0]         gain;
  logic [23:0]        per;
  logic               hp;
  logic               sr;
  logic               mxd;
  logic               cpx;
  logic               fen;
  logic [31:0]        cnt [5];
  logic [31:0]        cap_osc;
  logic [1:0]         cap_mix;
  logic               cap_hb;
  logic [31:0]        v;
  logic [23:0]        p;
  logic [15:0]        ph;
  integer             seed;
  int                 fails;
  int                 cmp_count;

  assign sdio_w = d_oe ? d_sdio : h_sdio;

  dsc_host host (.i_clk(i_clk), .i_sdio(sdio_w), .o_sclk(sclk), .o_csn(csn),
    .o_sdio(h_sdio), .o_sync(sync));

  dsc_sync_ctrl dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_sync(sync), .i_sclk(sclk),
    .i_csn(csn), .i_sdio(sdio_w), .i_mon_result_a(res_a), .i_mon_result_b(res_b),
    .o_sdio(d_sdio), .o_sdio_oe(d_oe), .o_sync(pls), .o_osc_phase(phs),
    .o_osc_tuning_word(ftw), .o_osc_enable(osc_en), .o_osc_amp_dither(amp_d),
    .o_osc_phase_dither(ph_d), .o_hb_phase(hb), .o_hb_high_pass(hp), .o_hb_spectral_rev(sr),
    .o_mix_phase(mix), .o_mix_disable(mxd), .o_complex_mode(cpx), .o_fir_enable(fen),
    .o_fir_gain(gain), .o_mon_period(per));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // pulses are one cycle wide, so count and capture them mid-cycle
  always @(negedge i_clk) begin
    for (int k = 0; k < 5; k++) cnt[k] += 32'(pls[k]);
    if (pls.osc) cap_osc = phs;
    if (pls.mix) cap_mix = mix;
    if (pls.hb) cap_hb = hb;
  end

  function automatic logic [1:0] exp_gain(input logic b);
    return b ? dsc_pkg::GAIN_ONE : dsc_pkg::GAIN_TWO;
  endfunction

  function automatic logic [23:0] exp_period(input logic [23:0] r);
    return (r < dsc_pkg::PERIOD_MIN) ? dsc_pkg::PERIOD_MIN : r;
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.xfer({3'h0, a}, d, r);
  endtask

  task automatic rdc(input logic [12:0] a, input logic [7:0] e);
    logic [7:0] r;
    host.xfer({3'h4, a}, 8'h00, r);
    chk($sformatf("reg %0h", a), 32'(e), 32'(r));
  endtask

  // e holds one nibble per unit: clkdiv osc hb mix mon
  task automatic burst(input int n, input logic [19:0] e);
    for (int k = 0; k < 5; k++) cnt[k] = 0;
    repeat (n) host.pulse();
    for (int k = 0; k < 5; k++) chk($sformatf("sync count %0d", k), 32'(e[4*k +: 4]), cnt[k]);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #600000;
    fails++;
    close_out();
  end

  initial begin
    seed = 32'hF163;
    i_reset_n = 1'b0;
    res_a = 20'h00000;
    res_b = 20'h00000;
    for (int k = 0; k < 5; k++) cnt[k] = 0;
    repeat (4) @(negedge i_clk);
    i_reset_n = 1'b1;
    repeat (4) @(negedge i_clk);
    chk("fir gain", 32'(exp_gain(1'b0)), 32'(gain));
    chk("mon period", 32'h00000080, 32'(per));
    rdc(dsc_pkg::ADDR_PERIOD0, 8'h80);
    rdc(dsc_pkg::ADDR_OSC_CTL, 8'h00);
    rdc(dsc_pkg::ADDR_FTW3, 8'h00);
    rdc(dsc_pkg::ADDR_PHASE1, 8'h00);
    rdc(13'h0130, 8'h00);
    wr(dsc_pkg::ADDR_SYNC_CTL, 8'hAA);
    wr(dsc_pkg::ADDR_MIX_CTL, 8'h01);
    burst(1, 20'h00000);
    ph = 16'($random(seed));
    wr(dsc_pkg::ADDR_PHASE0, ph[7:0]);
    wr(dsc_pkg::ADDR_PHASE1, ph[15:8]);
    wr(dsc_pkg::ADDR_SYNC_CTL, 8'hAB);
    for (int s = 0; s < 4; s++) begin
      wr(dsc_pkg::ADDR_MIX_CTL, {2'h0, 2'(s), 4'h1});
      wr(dsc_pkg::ADDR_HB_CTL, {4'h0, s[0], 3'h0});
      burst(1, 20'h11111);
      chk("mix start", 32'(s), 32'(cap_mix));
      chk("hb phase", 32'(s[0]), 32'(cap_hb));
      chk("osc phase", {ph, 16'h0000}, cap_osc);
    end
    rdc(dsc_pkg::ADDR_SYNC_CTL, 8'hAB);
    wr(dsc_pkg::ADDR_SYNC_CTL, 8'h7F);
    wr(dsc_pkg::ADDR_MIX_CTL, 8'h00);
    burst(2, 20'h11100);
    rdc(dsc_pkg::ADDR_SYNC_CTL, 8'h55);
    wr(dsc_pkg::ADDR_SYNC_CTL, 8'h81);
    wr(dsc_pkg::ADDR_MIX_CTL, 8'h03);
    burst(2, 20'h00011);
    rdc(dsc_pkg::ADDR_SYNC_CTL, 8'h80);
    // first draws stay below the floor of 128 on purpose
    for (int n = 0; n < 6; n++) begin
      v = $random(seed);
      p = (n < 3) ? {17'h00000, v[6:0]} : v[23:0];
      wr(dsc_pkg::ADDR_FIR_CTL, {4'h0, v[3:0]});
      chk("fir gain", 32'(exp_gain(v[3])), 32'(gain));
      chk("fir mode", 32'(v[2:0]), 32'({mxd, cpx, fen}));
      rdc(dsc_pkg::ADDR_FIR_CTL, {4'h0, v[3:0]});
      wr(dsc_pkg::ADDR_HB_CTL, v[15:8]);
      chk("hb mode", 32'(v[10:9]), 32'({sr, hp}));
      rdc(dsc_pkg::ADDR_HB_CTL, (v[15:8] & dsc_pkg::MASK_HB) | 8'h01);
      wr(dsc_pkg::ADDR_MIX_CTL, v[23:16]);
      rdc(dsc_pkg::ADDR_MIX_CTL, v[23:16] & dsc_pkg::MASK_MIX);
      wr(dsc_pkg::ADDR_PERIOD0, p[7:0]);
      wr(dsc_pkg::ADDR_PERIOD1, p[15:8]);
      wr(dsc_pkg::ADDR_PERIOD2, p[23:16]);
      chk("mon period", 32'(exp_period(p)), 32'(per));
      rdc(dsc_pkg::ADDR_PERIOD0, p[7:0]);
      wr(dsc_pkg::ADDR_FTW0, v[7:0]);
      wr(dsc_pkg::ADDR_FTW1, v[15:8]);
      wr(dsc_pkg::ADDR_FTW2, v[23:16]);
      wr(dsc_pkg::ADDR_FTW3, v[31:24]);
      chk("tuning word", v, ftw);
      wr(dsc_pkg::ADDR_OSC_CTL, {5'h00, v[2:0]});
      chk("osc ctl", 32'(v[2:0]), 32'({ph_d, amp_d, osc_en}));
      res_a = v[19:0];
      res_b = ~v[31:12];
      wr(dsc_pkg::ADDR_RES_A0, ~v[7:0]);
      rdc(dsc_pkg::ADDR_RES_A0, v[7:0]);
      rdc(dsc_pkg::ADDR_RES_A1, v[15:8]);
      rdc(dsc_pkg::ADDR_RES_A2, {4'h0, v[19:16]});
      rdc(dsc_pkg::ADDR_RES_B0, ~v[19:12]);
      rdc(dsc_pkg::ADDR_RES_B1, ~v[27:20]);
      rdc(dsc_pkg::ADDR_RES_B2, {4'h0, ~v[31:28]});
    end
    close_out();
  end
endmodule
